//--- apri_device.sv
/*
 Device end: fuse load, calibration and software reset.
 Assumes the host holds hw_reset low during software reset and
 waits for calibration before writing registers.
 Registers return to fuse defaults on either reset; the soft reset
 bit is never stored and so reads back as zero. Writes arriving
 before calibration ends are dropped.
*/
//
// Overview of operation
// - Host pulses reset high after power-up
// - Host waits 2 ms before config pin
// - Config pin and clock before reset
// - 100 ns config to reset rise
// - Reset release loads fuses, starts calibration
// - Calibration lasts 200000 clock cycles
// - Bit D0 at 0x00 resets registers
// - Soft reset bit clears itself
// - Host keeps reset pin low then
// - Host waits calibration before serial access
`timescale 1ns/1ps
module apri_device
#(
   // Calibration length; the bench may shorten it
   parameter int unsigned cal_len = apri_pkg::cal_cycles
)
(
   // Clock and enable
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              clk_en,
   // Link
   apri_if.device                 link,
   // User side
   output logic                   cal_busy,
   output logic                   reg_ready,
   output logic [7:0]             reg_view [apri_pkg::reg_count]
);
   import apri_pkg::*;

   // Pin synchronisers, two flops before use
   logic [1:0]      rst_sync;
   logic [1:0]      sel_sync;
   logic [1:0]      vld_sync;
   logic [1:0]      next_rst_sync;
   logic [1:0]      next_sel_sync;
   logic [1:0]      next_vld_sync;
   // Address and data staged alike, stable before valid
   logic [1:0][7:0] adr_sync;
   logic [1:0][7:0] next_adr_sync;
   logic [1:0][7:0] dat_sync;
   logic [1:0][7:0] next_dat_sync;
   logic            rst_q;
   logic            next_rst_q;

   apri_dev_e         state;
   apri_dev_e         next_state;
   logic [cnt_w-1:0]  cnt;
   logic [cnt_w-1:0]  next_cnt;
   logic [7:0]        regs      [reg_count];
   logic [7:0]        next_regs [reg_count];
   logic              soft_hit;
   logic              next_busy;
   logic              next_ready;
   logic              fuse_load;
   logic              reg_wr;

   // Shift pins into the synchronisers
   always_comb
   begin
      next_rst_sync = {rst_sync[0], link.hw_reset};
      next_sel_sync = {sel_sync[0], link.serial_select_pin};
      next_vld_sync = {vld_sync[0], link.wr_valid};
      next_adr_sync = {adr_sync[0], link.wr_addr};
      next_dat_sync = {dat_sync[0], link.wr_data};
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rst_sync <= 2'h0;
         sel_sync <= 2'h0;
         vld_sync <= 2'h0;
         adr_sync <= '0;
         dat_sync <= '0;
      end
      else if (clk_en)
      begin
         rst_sync <= next_rst_sync;
         sel_sync <= next_sel_sync;
         vld_sync <= next_vld_sync;
         adr_sync <= next_adr_sync;
         dat_sync <= next_dat_sync;
      end
   end

   // Write seen on synchronised select and valid rising edge
   logic wr_edge;
   logic vld_q;
   logic next_vld_q;
   assign wr_edge = vld_sync[1] & ~vld_q & sel_sync[1];

   assign soft_hit = wr_edge && (adr_sync[1] == reg_soft_reset) &&
                     dat_sync[1][soft_reset_bit];

   always_comb
   begin
      next_state = state;
      next_cnt   = cnt;
      next_rst_q = rst_sync[1];
      next_vld_q = vld_sync[1];
      fuse_load  = 1'b0;
      reg_wr     = 1'b0;
      if (rst_sync[1])
      begin
         // Held in reset while pin high
         next_state = apri_dev_idle;
         next_cnt   = '0;
      end
      else
      begin
         case (state)
            apri_dev_idle:
            begin
               if (rst_q)
                  next_state = apri_dev_load;
            end
            apri_dev_load:
            begin
               fuse_load  = 1'b1;
               next_cnt   = '0;
               next_state = apri_dev_cal;
            end
            apri_dev_cal:
            begin
               next_cnt = cnt + 1'b1;
               // Load cycle counts toward the length
               if (cnt == cnt_w'(cal_len - 2))
                  next_state = apri_dev_rdy;
            end
            apri_dev_rdy:
            begin
               if (soft_hit)
               begin
                  // soft bit never stored, reads zero
                  next_state = apri_dev_load;
               end
               // Addresses beyond the map are dropped
               else if (wr_edge && adr_sync[1] < 8'(reg_count) &&
                        adr_sync[1] != reg_soft_reset)
                  reg_wr = 1'b1;
            end
            default:
               next_state = apri_dev_idle;
         endcase
      end
      next_busy  = (next_state != apri_dev_rdy);
      next_ready = (next_state == apri_dev_rdy);
   end

   // Per-entry update; a fuse load overrides any write
   for (genvar g = 0; g < reg_count; g++)
   begin : g_reg
      always_comb
      begin
         next_regs[g] = regs[g];
         if (fuse_load)
            next_regs[g] = fuse_default;
         else if (reg_wr && adr_sync[1][1:0] == 2'(g))
            next_regs[g] = dat_sync[1];
      end
   end

   // Registered state; all of it freezes while clk_en is low
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state     <= apri_dev_idle;
         cnt       <= '0;
         rst_q     <= 1'b0;
         vld_q     <= 1'b0;
         cal_busy  <= 1'b1;
         reg_ready <= 1'b0;
         for (int i = 0; i < reg_count; i++)
            regs[i] <= reg_reset_value;
      end
      else if (clk_en)
      begin
         state     <= next_state;
         cnt       <= next_cnt;
         rst_q     <= next_rst_q;
         vld_q     <= next_vld_q;
         cal_busy  <= next_busy;
         reg_ready <= next_ready;
         regs      <= next_regs;
      end
   end

   assign reg_view       = regs;
   assign link.dev_ready = reg_ready;
endmodule // apri_device

//--- apri_host.sv
/*
 Host end: power-up sequencing, reset pulse, soft reset and waits.
 Assumes power is applied when reset is released.
*/
`timescale 1ns/1ps
module apri_host
#(
   parameter int unsigned pwr_cycles = apri_pkg::power_on_cycles,
   parameter int unsigned wait_cycles = apri_pkg::cal_cycles
)
(
   // Clock and enable
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              clk_en,
   // Link
   apri_if.host                   link,
   // User side
   input  wire logic              ref_level,
   input  wire logic              soft_req,
   input  wire logic              wr_req,
   input  wire logic [7:0]        wr_addr_in,
   input  wire logic [7:0]        wr_data_in,
   output logic                   host_ready
);
   import apri_pkg::*;

   apri_host_e        state;
   apri_host_e        next_state;
   logic [cnt_w-1:0]  cnt;
   logic [cnt_w-1:0]  next_cnt;
   logic              drv;
   logic              next_drv;
   logic              lvl;
   logic              next_lvl;
   logic              rst;
   logic              next_rst;
   logic              sel;
   logic              next_sel;
   logic              vld;
   logic              next_vld;
   logic [7:0]        adr;
   logic [7:0]        next_adr;
   logic [7:0]        dat;
   logic [7:0]        next_dat;

   always_comb
   begin
      next_state = state;
      next_cnt   = cnt + 1'b1;
      next_drv   = drv;
      next_lvl   = lvl;
      next_rst   = 1'b0;
      next_sel   = 1'b0;
      next_vld   = 1'b0;
      next_adr   = adr;
      next_dat   = dat;
      case (state)
         apri_host_pwr:
            if (cnt == cnt_w'(pwr_cycles - 1))
            begin
               next_drv   = 1'b1;
               next_lvl   = ref_level;
               next_cnt   = '0;
               next_state = apri_host_cfg;
            end
         apri_host_cfg:
            if (cnt == cnt_w'(cfg_to_reset_cycles - 1))
            begin
               next_cnt   = '0;
               next_rst   = 1'b1;
               next_state = apri_host_rst;
            end
         apri_host_rst:
         begin
            next_rst = 1'b1;
            if (cnt == cnt_w'(reset_width_cycles - 1))
            begin
               next_rst   = 1'b0;
               next_cnt   = '0;
               next_state = apri_host_wait;
            end
         end
         apri_host_wait:
            // wait out calibration and device ready
            if (cnt >= cnt_w'(wait_cycles - 1) && link.dev_ready)
               next_state = apri_host_ready;
         apri_host_ready:
         begin
            next_cnt = '0;
            if (soft_req)
            begin
               next_sel   = 1'b1;
               next_adr   = reg_soft_reset;
               next_dat   = 8'h01;
               next_state = apri_host_sreq;
            end
            else if (wr_req)
            begin
               next_sel   = 1'b1;
               next_adr   = wr_addr_in;
               next_dat   = wr_data_in;
               next_state = apri_host_sreq;
            end
         end
         apri_host_sreq:
         begin
            // Select and valid held several cycles for sync
            next_sel = 1'b1;
            next_vld = (cnt >= cnt_w'(1)) && (cnt < cnt_w'(6));
            if (cnt == cnt_w'(7))
            begin
               next_sel   = 1'b0;
               next_cnt   = '0;
               next_state = (adr == reg_soft_reset && dat[0]) ?
                            apri_host_wait : apri_host_ready;
            end
         end
         default:
            next_state = apri_host_pwr;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state      <= apri_host_pwr;
         cnt        <= '0;
         drv        <= 1'b0;
         lvl        <= 1'b0;
         rst        <= 1'b0;
         sel        <= 1'b0;
         vld        <= 1'b0;
         adr        <= 8'h00;
         dat        <= 8'h00;
         host_ready <= 1'b0;
      end
      else if (clk_en)
      begin
         state      <= next_state;
         cnt        <= next_cnt;
         drv        <= next_drv;
         lvl        <= next_lvl;
         rst        <= next_rst;
         sel        <= next_sel;
         vld        <= next_vld;
         adr        <= next_adr;
         dat        <= next_dat;
         host_ready <= (next_state == apri_host_ready);
      end
   end

   assign link.ref_cfg_drive     = drv;
   assign link.ref_cfg_level     = lvl;
   assign link.samp_clk_on       = drv;
   assign link.hw_reset          = rst;
   assign link.serial_select_pin = sel;
   assign link.wr_valid          = vld;
   assign link.wr_addr           = adr;
   assign link.wr_data           = dat;
endmodule // apri_host

//--- apri_if.sv
/*
 Interface joining host controller and device ends.
 Assumes both ends run on the same sampling clock.
*/
`timescale 1ns/1ps
interface apri_if;
   logic       ref_cfg_drive;
   logic       ref_cfg_level;
   logic       samp_clk_on;
   logic       hw_reset;
   logic       serial_select_pin;
   logic       wr_valid;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic       dev_ready;

   modport host
   (
      output ref_cfg_drive, ref_cfg_level, samp_clk_on, hw_reset,
      output serial_select_pin, wr_valid, wr_addr, wr_data,
      input  dev_ready
   );
   modport device
   (
      input  ref_cfg_drive, ref_cfg_level, samp_clk_on, hw_reset,
      input  serial_select_pin, wr_valid, wr_addr, wr_data,
      output dev_ready
   );
endinterface // apri_if

//--- apri_pkg.sv
/*
 Package for the power-up and reset initialisation block.
 Holds timing constants, register layout and state enumerations.
 Assumes one clock at 20 MHz shared by both ends.
*/
package apri_pkg;
   localparam int unsigned clk_period_ns     = 50;
   // Power-on delay before config pin is driven, in ms
   localparam int unsigned power_on_ms       = 2;
   localparam int unsigned power_on_cycles   =
      (power_on_ms * 1000000 + clk_period_ns - 1) / clk_period_ns;
   // Config pin settled to reset rising edge, in ns
   localparam int unsigned cfg_to_reset_ns   = 100;
   localparam int unsigned cfg_to_reset_cycles =
      (cfg_to_reset_ns + clk_period_ns - 1) / clk_period_ns;
   // Reset pulse width, in us
   localparam int unsigned reset_width_us    = 1;
   localparam int unsigned reset_width_cycles =
      (reset_width_us * 1000 + clk_period_ns - 1) / clk_period_ns;
   // Calibration length in sampling-clock cycles
   localparam int unsigned cal_cycles        = 200000;
   // Serial register map
   localparam logic [7:0]  reg_soft_reset    = 8'h00;
   localparam int unsigned soft_reset_bit    = 0;
   localparam int unsigned reg_count         = 4;
   localparam logic [7:0]  reg_reset_value   = 8'h00;
   localparam logic [7:0]  fuse_default      = 8'h00;
   localparam int unsigned cnt_w             = 24;

   typedef enum logic [1:0]
   {
      apri_dev_idle = 2'b00,
      apri_dev_load = 2'b01,
      apri_dev_cal  = 2'b11,
      apri_dev_rdy  = 2'b10
   } apri_dev_e;

   typedef enum logic [2:0]
   {
      apri_host_pwr   = 3'b000,
      apri_host_cfg   = 3'b001,
      apri_host_rst   = 3'b011,
      apri_host_wait  = 3'b010,
      apri_host_ready = 3'b110,
      apri_host_sreq  = 3'b111
   } apri_host_e;
endpackage

//--- apri_sva.sv
/*
 Checker for the link between host and device ends.
 Assumes one clock; placed beside the interface in the bench.
*/
`timescale 1ns/1ps
module apri_sva
   import apri_pkg::*;
#(
   parameter int unsigned pwr_cycles = 10,
   parameter int unsigned cal_len    = cal_cycles
)
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       reset,
   // Link
   input wire logic       ref_cfg_drive,
   input wire logic       samp_clk_on,
   input wire logic       hw_reset,
   input wire logic       serial_select_pin,
   input wire logic       wr_valid,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic       dev_ready
);
   // Calibration may run up to cal_len / 200 cycles (half a percent) short of or beyond its nominal length
   localparam int unsigned cal_lo = cal_len - cal_len / 200;
   localparam int unsigned cal_hi = cal_len + cal_len / 200;
   int unsigned up_cnt;
   int unsigned hi_cnt;
   int unsigned cal_cnt;
   int unsigned next_up_cnt;
   int unsigned next_hi_cnt;
   int unsigned next_cal_cnt;

   // Time since release, reset width, calibration length
   always_comb
   begin
      next_up_cnt  = up_cnt + 1;
      next_hi_cnt  = hw_reset ? hi_cnt + 1 : 0;
      next_cal_cnt = (hw_reset || dev_ready) ? 0 : cal_cnt + 1;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         up_cnt  <= 0;
         hi_cnt  <= 0;
         cal_cnt <= 0;
      end
      else
      begin
         up_cnt  <= next_up_cnt;
         hi_cnt  <= next_hi_cnt;
         cal_cnt <= next_cal_cnt;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence soft_wr;
      $rose(wr_valid) && serial_select_pin && dev_ready &&
         wr_addr == reg_soft_reset && wr_data[0];
   endsequence

   reset_width_a : assert property (
      $fell(hw_reset) |-> hi_cnt >= reset_width_cycles)
      else $error("reset pulse short");
   power_wait_a : assert property (
      $rose(ref_cfg_drive) |-> up_cnt >= pwr_cycles)
      else $error("config pin driven early");
   cfg_first_a : assert property (
      $rose(hw_reset) |-> ref_cfg_drive && samp_clk_on)
      else $error("reset before config and clock");
   cfg_setup_a : assert property (
      $rose(hw_reset) |-> $past(ref_cfg_drive, 2))
      else $error("config to reset too short");
   cal_start_a : assert property (
      $fell(hw_reset) |-> !dev_ready [*8]) else $error("ready too soon");
   cal_length_a : assert property (
      $rose(dev_ready) |-> cal_cnt >= cal_lo && cal_cnt <= cal_hi)
      else $error("calibration length wrong");
   soft_drop_a : assert property (
      soft_wr |-> ##[1:8] !dev_ready) else $error("soft reset not taken");
   soft_hold_a : assert property (
      soft_wr |-> !hw_reset [*8]) else $error("reset pin high in soft reset");
   select_wait_a : assert property (
      $rose(serial_select_pin) |-> dev_ready)
      else $error("select before ready");
endmodule // apri_sva

//--- test_adc_powerup_reset_init.sv
/*
 Testbench joining host and device ends through the interface.
 Assumes the package constants and a 20 MHz clock.
*/
`timescale 1ns/1ps
module test_adc_powerup_reset_init;
   import apri_pkg::*;
   localparam int unsigned pwr_c = 10;
   localparam int unsigned cal_c = 2000;
   logic       clk        = 1'b0;
   logic       reset      = 1'b1;
   logic       ref_level  = 1'b1;
   logic       soft_req   = 1'b0;
   logic       wr_req     = 1'b0;
   logic [7:0] wr_addr_in = 8'h00;
   logic [7:0] wr_data_in = 8'h00;
   logic       host_ready;
   logic       cal_busy;
   logic       reg_ready;
   logic [7:0] reg_view [reg_count];
   int         error_cnt    = 0;
   int         total_checks = 0;

   apri_if link ();

   always #25 clk = ~clk;

   apri_host #(.pwr_cycles(pwr_c), .wait_cycles(cal_c)) i_apri_host
   (
      .clk(clk), .reset(reset), .clk_en(1'b1), .link(link),
      .ref_level(ref_level), .soft_req(soft_req), .wr_req(wr_req),
      .wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in),
      .host_ready(host_ready)
   );
   apri_device #(.cal_len(cal_c)) i_apri_device
   (
      .clk(clk), .reset(reset), .clk_en(1'b1), .link(link),
      .cal_busy(cal_busy), .reg_ready(reg_ready), .reg_view(reg_view)
   );
   apri_sva #(.pwr_cycles(pwr_c), .cal_len(cal_c)) i_apri_sva
   (
      .clk(clk), .reset(reset), .ref_cfg_drive(link.ref_cfg_drive),
      .samp_clk_on(link.samp_clk_on), .hw_reset(link.hw_reset),
      .serial_select_pin(link.serial_select_pin),
      .wr_valid(link.wr_valid), .wr_addr(link.wr_addr),
      .wr_data(link.wr_data), .dev_ready(link.dev_ready)
   );

   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk_bit(input logic act, input logic exp, input string m);
      total_checks++;
      if (act !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask

   task automatic chk_byte(input logic [7:0] act, input logic [7:0] exp);
      total_checks++;
      if (act !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: byte %h not %h", $time, act, exp);
      end
   endtask

   // Bounded wait for the host to accept requests
   task automatic wait_host(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         #1;
         if (host_ready === 1'b1)
            return;
      end
      error_cnt++;
      $display("unexpected at %0t: host never ready", $time);
      close_out();
   endtask

   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      wait_host(20);
      @(posedge clk);
      wr_addr_in <= a;
      wr_data_in <= d;
      wr_req     <= 1'b1;
      @(posedge clk);
      wr_req <= 1'b0;
      repeat (12) @(posedge clk);
      wait_host(20);
   endtask

   initial
   begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      chk_bit(link.hw_reset, 1'b0, "reset before power wait");
      wait_host(cal_c + 500);
      chk_bit(link.ref_cfg_level, 1'b1, "config level");
      chk_bit(link.dev_ready, 1'b1, "device not ready");
      chk_bit(cal_busy, 1'b0, "calibration still busy");
      for (int i = 0; i < reg_count; i++)
         chk_byte(reg_view[i], fuse_default);
      for (int i = 1; i < reg_count; i++)
         write_reg(8'(i), 8'ha0 + 8'(i));
      write_reg(8'h04, 8'h55);
      chk_byte(reg_view[0], 8'h00);
      for (int i = 1; i < reg_count; i++)
         chk_byte(reg_view[i], 8'ha0 + 8'(i));
      @(posedge clk);
      soft_req <= 1'b1;
      @(posedge clk);
      soft_req <= 1'b0;
      repeat (20) @(posedge clk);
      #1;
      chk_bit(link.dev_ready, 1'b0, "soft reset ignored");
      chk_bit(link.hw_reset, 1'b0, "reset pin raised");
      chk_bit(cal_busy, 1'b1, "no recalibration");
      chk_byte(reg_view[2], fuse_default);
      wait_host(cal_c + 500);
      chk_bit(reg_ready, 1'b1, "not ready after soft reset");
      chk_byte(reg_view[0], 8'h00);
      chk_byte(reg_view[3], fuse_default);
      close_out();
   end
endmodule // test_adc_powerup_reset_init
